/* File: pkg/adcsq_pkg.sv */
/*
  Shared constants for the converter autosequencer control block: register
  addresses, field positions, reset values, timing counts and the converter
  state type. Assumes a 16-bit register port and a 100 MHz system clock.
*/
package adcsq_pkg;

  // Sizes
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned CODE_W    = 12;
  localparam int unsigned SLOT_W    = 4;
  localparam int unsigned NUM_SLOTS = 16;
  localparam int unsigned WIN_SIZE  = 16;

  // Register addresses
  localparam logic [15:0] ADDR_CTRL1      = 16'h7100;
  localparam logic [15:0] ADDR_CTRL2      = 16'h7101;
  localparam logic [15:0] ADDR_MAXCONV    = 16'h7102;
  localparam logic [15:0] ADDR_CHSEL0     = 16'h7103;
  localparam logic [15:0] ADDR_SEQ_STATUS = 16'h7107;
  localparam logic [15:0] ADDR_RES_SLOW   = 16'h7108;
  localparam logic [15:0] ADDR_CTRL3      = 16'h7118;
  localparam logic [15:0] ADDR_STATUS     = 16'h7119;
  localparam logic [15:0] ADDR_REFSEL     = 16'h711c;
  localparam logic [15:0] ADDR_RES_FAST   = 16'h0b00;

  // Reset values
  localparam logic [15:0] CTRL1_RESET   = 16'h0000;
  localparam logic [15:0] CTRL2_RESET   = 16'h0000;
  localparam logic [15:0] MAXCONV_RESET = 16'h0000;
  localparam logic [15:0] CHSEL_RESET   = 16'h0000;
  localparam logic [15:0] CTRL3_RESET   = 16'h0000;
  localparam logic [15:0] REFSEL_RESET  = 16'h0000;

  // Control 1 fields
  localparam int unsigned CTRL1_ACQ_LSB = 8;
  localparam int unsigned ACQ_W         = 4;
  localparam int unsigned CTRL1_CONT    = 6;
  localparam int unsigned CTRL1_STEP    = 5;
  localparam int unsigned CTRL1_CASC    = 4;

  // Control 2 fields
  localparam int unsigned CTRL2_PWMB_CASC = 15;
  localparam int unsigned CTRL2_RST1      = 14;
  localparam int unsigned CTRL2_SOC1      = 13;
  localparam int unsigned CTRL2_INT_EN1   = 11;
  localparam int unsigned CTRL2_INT_MODE1 = 10;
  localparam int unsigned CTRL2_EXT_EN1   = 9;
  localparam int unsigned CTRL2_PWMA_EN1  = 8;
  localparam int unsigned CTRL2_RST2      = 6;
  localparam int unsigned CTRL2_SOC2      = 5;
  localparam int unsigned CTRL2_INT_EN2   = 3;
  localparam int unsigned CTRL2_INT_MODE2 = 2;
  localparam int unsigned CTRL2_PWMB_EN2  = 0;
  localparam logic [15:0] CTRL2_PULSE_MASK = 16'h6060;

  // Maximum conversion fields
  localparam int unsigned MAXC_CASC_LSB = 0;
  localparam int unsigned MAXC_SEQ1_LSB = 0;
  localparam int unsigned MAXC_SEQ2_LSB = 4;

  // Control 3 and reference select fields
  localparam int unsigned CTRL3_CPS_LSB = 0;
  localparam int unsigned CPS_W         = 4;
  localparam int unsigned REFSEL_LSB    = 14;

  // Timing counts
  localparam logic [1:0] HSP_DIV_LAST = 2'h1;
  localparam logic [3:0] CONV_LAST    = 4'hb;

  // Transfer function
  localparam logic [27:0] FULL_SCALE_MV = 28'h0000bb8;
  localparam logic [27:0] CODE_MAX      = 28'h0000fff;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_ACQUIRE,
    CONV_CONVERT,
    CONV_STORE
  } adcsq_conv_state_t;

endpackage

/* File: rtl/adcsq_result_mem.sv */
/*
  Sixteen-word result store of the converter control block.
  One write port, one read port with registered read data; single clock.
*/
`timescale 1ns/1ps
module adcsq_result_mem
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [11:0] wr_data,
  input  wire logic        rd_en,
  input  wire logic [3:0]  rd_addr,
  output logic      [11:0] rd_data
);

  logic [11:0] mem [adcsq_pkg::NUM_SLOTS];

  // Storage
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data <= 12'h000;
    end
    else if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // adcsq_result_mem

/* File: rtl/adcsq_control.sv */
/*
  Autosequencer control around one 12-bit sampling converter: registers,
  two 8-slot or one 16-slot sequencer, triggers, timing and result storage.
  Assumes synchronous trigger inputs and a digitised input level in mV.
*/
// How it works
// [R1] Every slot holds any of sixteen channels; one session runs up to sixteen.
// [R2] Cascade bit joins two eight-slot sequencers into one sixteen-slot sequencer.
// [R3] In dual mode each sequencer only reaches its own eight channels.
// [R4] One converter serves the sequencers one conversion at a time.
// [R5] Each finished conversion lands in the result word of its slot.
// [R6] Code is zero at or below low level, scaled by 4096/3 V, capped 4095.
// [R7] Software, PWM pulse or external interrupt pin can start a sequence.
// [R8] End-of-sequence request fires on every end or every second end.
// [R9] Start/stop mode converts one slot per trigger.
// [R10] In dual mode PWM trigger a drives sequencer one, b drives two.
// [R11] Acquisition window has its own length field.
// [R12] Any channel may appear in several slots.
// [R13] Registers run on system clock; sequencing on fast peripheral clock enable.
// [R14] Clock enable resets low; registers reset; analog section stays powered down.
// [R15] After reset, register access waits for clock enable; enable powers analog.
// [R16] Software waits a settling time after enabling before converting.
// [R17] Halt powers analog down and keeps every register.
// [R18] Bits 15:14 of reference select choose internal or external reference.
// [R19] Results read left-justified in one window, right-justified in another.
// [R20] After its last slot a sequencer signals end and returns to its first.
`timescale 1ns/1ps
module adcsq_control
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        converter_clock_enable,
  input  wire logic        halt,
  input  wire logic        pwm_conversion_trigger_a,
  input  wire logic        pwm_conversion_trigger_b,
  input  wire logic        external_interrupt_two,
  input  wire logic [15:0] analog_input_voltage,
  input  wire logic [15:0] analog_low_reference,
  output logic      [3:0]  mux_channel,
  output logic             sample_hold,
  output logic             analog_power_up,
  output logic      [1:0]  reference_select,
  output logic             int_seq1,
  output logic             int_seq2
);

  logic [15:0]                    ctrl1;
  logic [15:0]                    ctrl2;
  logic [15:0]                    maxconv;
  logic [15:0]                    ctrl3;
  logic [15:0]                    refsel;
  logic [63:0]                    chsel;
  logic                           bus_on;
  logic                           wr_ok;
  logic                           casc;
  logic                           run_clk;
  logic [1:0]                     hsp_cnt;
  logic                           hsp_tick;
  logic [3:0]                     pre_cnt;
  logic                           conv_tick;
  logic [3:0]                     acq_cnt;
  logic [3:0]                     bit_cnt;
  adcsq_pkg::adcsq_conv_state_t   conv_state;
  logic                           grant_q;
  logic                           next_grant;
  logic [3:0]                     slot_q;
  logic [11:0]                    sample_code;
  logic                           finish;
  logic [1:0]                     trig;
  logic [1:0]                     seq_reset;
  logic [1:0]                     run;
  logic [1:0]                     end_of_sequence;
  logic [1:0]                     eos_cnt;
  logic [1:0]                     int_q;
  logic [3:0]                     ptr [2];
  logic [15:0]                    reg_value;
  logic [15:0]                    rdata_q;
  logic                           res_sel_q;
  logic                           left_q;
  logic                           in_slow;
  logic                           in_fast;
  logic [3:0]                     res_index;
  logic [11:0]                    mem_q;

  function automatic logic in_window(input logic [15:0] a, input logic [15:0] base);
    return (a >= base) && (a < base + 16'(adcsq_pkg::WIN_SIZE));
  endfunction

  function automatic logic [3:0] first_slot(input logic s, input logic cascade);
    return (s && !cascade) ? 4'h8 : 4'h0;
  endfunction

  function automatic logic [3:0] last_slot(input logic s, input logic cascade,
                                           input logic [15:0] mc);
    if (cascade)
      return mc[adcsq_pkg::MAXC_CASC_LSB +: 4];
    else if (s)
      return {1'b1, mc[adcsq_pkg::MAXC_SEQ2_LSB +: 3]};
    else
      return {1'b0, mc[adcsq_pkg::MAXC_SEQ1_LSB +: 3]};
  endfunction

  // [R1] Slot to channel decode
  function automatic logic [3:0] slot_channel(input logic [3:0] slot, input logic cascade,
                                              input logic [63:0] sel);
    logic [3:0] nib;
    nib = sel[{slot, 2'b00} +: 4];
    // [R3] Dual mode group limit
    return cascade ? nib : {slot[3], nib[2:0]};
  endfunction

  // [R6] Transfer function
  function automatic logic [11:0] code_of(input logic [15:0] vin, input logic [15:0] vlo);
    logic [27:0] scaled;
    logic [27:0] quo;
    scaled = {vin - vlo, 12'h000};
    quo = scaled / adcsq_pkg::FULL_SCALE_MV;
    if (vin <= vlo)
      return 12'h000;
    else if (quo > adcsq_pkg::CODE_MAX)
      return 12'hfff;
    else
      return quo[11:0];
  endfunction

  // [R15] Register access needs clock enable
  assign bus_on = converter_clock_enable;
  assign wr_ok  = wr && bus_on;
  // [R2] Cascade selection
  assign casc   = ctrl1[adcsq_pkg::CTRL1_CASC];

  // [R14] Analog section power
  assign analog_power_up = rst_b && converter_clock_enable && !halt;

  // [R18] Reference choice
  assign reference_select = refsel[adcsq_pkg::REFSEL_LSB +: 2];

  // Control registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl1   <= adcsq_pkg::CTRL1_RESET;
      ctrl2   <= adcsq_pkg::CTRL2_RESET;
      maxconv <= adcsq_pkg::MAXCONV_RESET;
      ctrl3   <= adcsq_pkg::CTRL3_RESET;
      refsel  <= adcsq_pkg::REFSEL_RESET;
    end
    else if (wr_ok)
    begin
      case (addr)
        adcsq_pkg::ADDR_CTRL1:   ctrl1   <= wdata;
        adcsq_pkg::ADDR_CTRL2:   ctrl2   <= wdata & ~adcsq_pkg::CTRL2_PULSE_MASK;
        adcsq_pkg::ADDR_MAXCONV: maxconv <= wdata;
        adcsq_pkg::ADDR_CTRL3:   ctrl3   <= wdata;
        adcsq_pkg::ADDR_REFSEL:  refsel  <= wdata;
        default:                 ctrl1   <= ctrl1;
      endcase
    end
  end

  // Channel select registers
  for (genvar g = 0; g < 4; g++)
  begin : g_chsel
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        chsel[g*16 +: 16] <= adcsq_pkg::CHSEL_RESET;
      end
      else if (wr_ok && addr == adcsq_pkg::ADDR_CHSEL0 + 16'(g))
      begin
        chsel[g*16 +: 16] <= wdata;
      end
    end
  end

  // Self-clearing commands
  always_comb
  begin
    seq_reset[0] = wr_ok && addr == adcsq_pkg::ADDR_CTRL2 && wdata[adcsq_pkg::CTRL2_RST1];
    seq_reset[1] = wr_ok && addr == adcsq_pkg::ADDR_CTRL2 && wdata[adcsq_pkg::CTRL2_RST2];
    // [R7] Start sources
    trig[0] = (wr_ok && addr == adcsq_pkg::ADDR_CTRL2 && wdata[adcsq_pkg::CTRL2_SOC1])
            || (pwm_conversion_trigger_a && ctrl2[adcsq_pkg::CTRL2_PWMA_EN1])
            || (external_interrupt_two && ctrl2[adcsq_pkg::CTRL2_EXT_EN1])
            || (casc && pwm_conversion_trigger_b && ctrl2[adcsq_pkg::CTRL2_PWMB_CASC]);
    // [R10] Separate trigger b
    trig[1] = !casc && ((wr_ok && addr == adcsq_pkg::ADDR_CTRL2
                         && wdata[adcsq_pkg::CTRL2_SOC2])
            || (pwm_conversion_trigger_b && ctrl2[adcsq_pkg::CTRL2_PWMB_EN2]));
    trig = bus_on ? trig : 2'b00;
  end

  // [R13] Fast peripheral clock enable
  // [R17] Halt freezes timing
  assign run_clk  = converter_clock_enable && !halt;
  assign hsp_tick = run_clk && hsp_cnt == adcsq_pkg::HSP_DIV_LAST;
  assign conv_tick = hsp_tick && pre_cnt == ctrl3[adcsq_pkg::CTRL3_CPS_LSB +: adcsq_pkg::CPS_W];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hsp_cnt <= 2'h0;
      pre_cnt <= 4'h0;
    end
    else if (run_clk)
    begin
      hsp_cnt <= hsp_tick ? 2'h0 : hsp_cnt + 2'h1;
      if (hsp_tick)
      begin
        pre_cnt <= conv_tick ? 4'h0 : pre_cnt + 4'h1;
      end
    end
  end

  // Sequencers
  for (genvar s = 0; s < 2; s++)
  begin : g_seq
    logic       done_here;
    logic       at_last;
    logic [3:0] first;
    logic       int_mode;
    logic       int_en;
    assign first     = first_slot(s == 1, casc);
    assign at_last   = ptr[s] == last_slot(s == 1, casc, maxconv);
    assign done_here = finish && (grant_q == (s == 1));
    assign int_mode  = ctrl2[s == 0 ? adcsq_pkg::CTRL2_INT_MODE1 : adcsq_pkg::CTRL2_INT_MODE2];
    assign int_en    = ctrl2[s == 0 ? adcsq_pkg::CTRL2_INT_EN1 : adcsq_pkg::CTRL2_INT_EN2];
    // [R20] End of sequence
    assign end_of_sequence[s]    = done_here && at_last;

    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        ptr[s] <= (s == 1) ? 4'h8 : 4'h0;
        run[s] <= 1'b0;
      end
      else
      begin
        // [R20] Wrap to first slot
        if (seq_reset[s])
          ptr[s] <= first;
        else if (done_here)
          ptr[s] <= at_last ? first : ptr[s] + 4'h1;
        // [R9] Stop after one slot in start/stop mode
        if (seq_reset[s])
          run[s] <= 1'b0;
        else if (trig[s])
          run[s] <= 1'b1;
        else if (done_here && (ctrl1[adcsq_pkg::CTRL1_STEP]
                 || (at_last && !ctrl1[adcsq_pkg::CTRL1_CONT])))
          run[s] <= 1'b0;
      end
    end

    // [R8] Every or every second end
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        eos_cnt[s] <= 1'b0;
        int_q[s]   <= 1'b0;
      end
      else
      begin
        int_q[s] <= end_of_sequence[s] && int_en && (!int_mode || eos_cnt[s]);
        if (seq_reset[s])
          eos_cnt[s] <= 1'b0;
        else if (end_of_sequence[s])
          eos_cnt[s] <= !eos_cnt[s];
      end
    end
  end

  assign int_seq1 = int_q[0];
  assign int_seq2 = int_q[1];

  // [R4] Sequencer one has priority for the single converter
  assign next_grant = !run[0];
  assign finish     = conv_state == adcsq_pkg::CONV_STORE;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      conv_state  <= adcsq_pkg::CONV_IDLE;
      grant_q     <= 1'b0;
      slot_q      <= 4'h0;
      mux_channel <= 4'h0;
      sample_hold <= 1'b0;
      sample_code <= 12'h000;
      acq_cnt     <= 4'h0;
      bit_cnt     <= 4'h0;
    end
    else
    begin
      case (conv_state)
        adcsq_pkg::CONV_IDLE:
        begin
          if (run_clk && (run[0] || run[1]))
          begin
            grant_q     <= next_grant;
            slot_q      <= ptr[next_grant];
            // [R12] Channel per slot, repeats allowed
            mux_channel <= slot_channel(ptr[next_grant], casc, chsel);
            sample_hold <= 1'b1;
            acq_cnt     <= 4'h0;
            conv_state  <= adcsq_pkg::CONV_ACQUIRE;
          end
        end
        adcsq_pkg::CONV_ACQUIRE:
        begin
          // [R11] Acquisition length
          if (hsp_tick)
          begin
            if (acq_cnt == ctrl1[adcsq_pkg::CTRL1_ACQ_LSB +: adcsq_pkg::ACQ_W])
            begin
              sample_hold <= 1'b0;
              sample_code <= code_of(analog_input_voltage, analog_low_reference);
              bit_cnt     <= 4'h0;
              conv_state  <= adcsq_pkg::CONV_CONVERT;
            end
            else
            begin
              acq_cnt <= acq_cnt + 4'h1;
            end
          end
        end
        adcsq_pkg::CONV_CONVERT:
        begin
          if (conv_tick)
          begin
            if (bit_cnt == adcsq_pkg::CONV_LAST)
              conv_state <= adcsq_pkg::CONV_STORE;
            else
              bit_cnt <= bit_cnt + 4'h1;
          end
        end
        default:
        begin
          conv_state <= adcsq_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // [R5] Result store per slot
  adcsq_result_mem u_results
  (
    .clock   (clock),
    .rst_b   (rst_b),
    .wr_en   (finish),
    .wr_addr (slot_q),
    .wr_data (sample_code),
    .rd_en   (rd && bus_on && (in_slow || in_fast)),
    .rd_addr (res_index),
    .rd_data (mem_q)
  );

  // Register read decode
  assign in_slow   = in_window(addr, adcsq_pkg::ADDR_RES_SLOW);
  assign in_fast   = in_window(addr, adcsq_pkg::ADDR_RES_FAST);
  assign res_index = in_slow ? 4'(addr - adcsq_pkg::ADDR_RES_SLOW) : addr[3:0];

  always_comb
  begin
    reg_value = 16'h0000;
    if (addr >= adcsq_pkg::ADDR_CHSEL0 && addr < adcsq_pkg::ADDR_SEQ_STATUS)
      reg_value = chsel[{2'(addr - adcsq_pkg::ADDR_CHSEL0), 4'h0} +: 16];
    case (addr)
      adcsq_pkg::ADDR_CTRL1:      reg_value = ctrl1;
      adcsq_pkg::ADDR_CTRL2:      reg_value = ctrl2;
      adcsq_pkg::ADDR_MAXCONV:    reg_value = maxconv;
      adcsq_pkg::ADDR_SEQ_STATUS: reg_value = {8'h00, ptr[1], ptr[0]};
      adcsq_pkg::ADDR_CTRL3:      reg_value = ctrl3;
      adcsq_pkg::ADDR_STATUS:     reg_value = {11'h000, eos_cnt,
                                               conv_state != adcsq_pkg::CONV_IDLE, run};
      adcsq_pkg::ADDR_REFSEL:     reg_value = refsel;
      default:                    reg_value = reg_value;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q   <= 16'h0000;
      res_sel_q <= 1'b0;
      left_q    <= 1'b0;
    end
    else
    begin
      rdata_q   <= (rd && bus_on) ? reg_value : 16'h0000;
      res_sel_q <= rd && bus_on && (in_slow || in_fast);
      left_q    <= in_slow;
    end
  end

  // [R19] Two result windows
  assign rdata = res_sel_q ? (left_q ? {mem_q, 4'h0} : {4'h0, mem_q}) : rdata_q;

  a_dual_group: assert property (@(posedge clock) disable iff (!rst_b) // [R3]
    (conv_state == adcsq_pkg::CONV_ACQUIRE && !casc) |-> mux_channel[3] == grant_q)
    else $error("dual mode channel outside group");

  a_single_grant: assert property (@(posedge clock) disable iff (!rst_b) // [R4]
    (conv_state != adcsq_pkg::CONV_IDLE) |=> (conv_state == adcsq_pkg::CONV_IDLE
      || $stable(grant_q)))
    else $error("grant changed during conversion");

  a_code_value: assert property (@(posedge clock) disable iff (!rst_b) // [R6]
    (hsp_tick && conv_state == adcsq_pkg::CONV_ACQUIRE
     && acq_cnt == ctrl1[adcsq_pkg::CTRL1_ACQ_LSB +: adcsq_pkg::ACQ_W])
    |=> conv_state == adcsq_pkg::CONV_CONVERT
        && sample_code == code_of($past(analog_input_voltage), $past(analog_low_reference)))
    else $error("sample code or acquisition end wrong");

  a_sw_start: assert property (@(posedge clock) disable iff (!rst_b) // [R7]
    (wr && bus_on && addr == adcsq_pkg::ADDR_CTRL2 && wdata[adcsq_pkg::CTRL2_SOC1]
     && !wdata[adcsq_pkg::CTRL2_RST1]) |=> run[0])
    else $error("software start not taken");

  a_int_every: assert property (@(posedge clock) disable iff (!rst_b) // [R8]
    (end_of_sequence[0] && ctrl2[adcsq_pkg::CTRL2_INT_EN1] && !ctrl2[adcsq_pkg::CTRL2_INT_MODE1])
    |=> int_seq1 ##1 !int_seq1)
    else $error("end of sequence request missing");

  a_eos_wrap: assert property (@(posedge clock) disable iff (!rst_b) // [R20]
    (end_of_sequence[0] && !seq_reset[0]) |=> ptr[0] == first_slot(1'b0, casc))
    else $error("sequencer did not return to first slot");

  a_enable_gate: assert property (@(posedge clock) disable iff (!rst_b) // [R15]
    (wr && !converter_clock_enable) |=> $stable(ctrl1) && $stable(refsel))
    else $error("register changed without clock enable");

  a_halt_power: assert property (@(posedge clock) disable iff (!rst_b) // [R17]
    halt |-> !analog_power_up && !hsp_tick ##1 $stable(ctrl1))
    else $error("halt left analog powered or ticks running");

  a_conv_length: assert property (@(posedge clock) disable iff (!rst_b) // [R5]
    (conv_state == adcsq_pkg::CONV_STORE) |-> $past(conv_tick)
      && $past(bit_cnt) == adcsq_pkg::CONV_LAST)
    else $error("store without full conversion");

endmodule // adcsq_control

/* File: test/adcsq_far_model.sv */
/*
  Far side of the converter control block: channel input levels and PWM start pulses.
  Assumes one-cycle trigger requests from the bench on the system clock.
*/
`timescale 1ns/1ps
module adcsq_far_model
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [3:0]  mux_channel,
  input  wire logic        fire_a,
  input  wire logic        fire_b,
  output logic      [15:0] analog_input_voltage,
  output logic             pwm_conversion_trigger_a,
  output logic             pwm_conversion_trigger_b
);
  // Level in mV of the selected channel
  assign analog_input_voltage = 16'h01f4 + 16'h00c8 * {12'h000, mux_channel};

  // One-cycle start pulses
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwm_conversion_trigger_a <= 1'b0;
      pwm_conversion_trigger_b <= 1'b0;
    end
    else
    begin
      pwm_conversion_trigger_a <= fire_a;
      pwm_conversion_trigger_b <= fire_b;
    end
  end
endmodule // adcsq_far_model

/* File: test/adc_autosequencer_control_bench.sv */
/*
  Self-checking bench for the converter control block.
  Assumes the far-side model adcsq_far_model and a 100 MHz clock.
*/
`timescale 1ns/1ps
module adc_autosequencer_control_bench;
  logic        clock;
  logic        rst_b;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        converter_clock_enable;
  logic        halt;
  logic        fire_a;
  logic        fire_b;
  logic        trig_a;
  logic        trig_b;
  logic        external_interrupt_two;
  logic [15:0] analog_input_voltage;
  logic [15:0] analog_low_reference;
  logic [3:0]  mux_channel;
  logic        sample_hold;
  logic        analog_power_up;
  logic [1:0]  reference_select;
  logic        int_seq1;
  logic        int_seq2;
  int          errors;
  int          n_compared;
  int          sh_cnt;
  int          int_cnt;

  adcsq_control dut_u (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .converter_clock_enable(converter_clock_enable), .halt(halt),
    .pwm_conversion_trigger_a(trig_a), .pwm_conversion_trigger_b(trig_b),
    .external_interrupt_two(external_interrupt_two),
    .analog_input_voltage(analog_input_voltage), .analog_low_reference(analog_low_reference),
    .mux_channel(mux_channel), .sample_hold(sample_hold), .analog_power_up(analog_power_up),
    .reference_select(reference_select), .int_seq1(int_seq1), .int_seq2(int_seq2));

  adcsq_far_model far_u (.clock(clock), .rst_b(rst_b), .mux_channel(mux_channel),
    .fire_a(fire_a), .fire_b(fire_b), .analog_input_voltage(analog_input_voltage),
    .pwm_conversion_trigger_a(trig_a), .pwm_conversion_trigger_b(trig_b));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // Bounded wait for an end-of-sequence pulse
  task automatic wait_int(input logic which);
    int n;
    n = 0;
    while ((which ? int_seq2 : int_seq1) !== 1'b1 && n < 600)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check({15'h0000, which ? int_seq2 : int_seq1}, 16'h0001);
  endtask

  // One software trigger, then count hold cycles and requests
  task automatic step;
    wr_reg(adcsq_pkg::ADDR_CTRL2, 16'h2c00);
    repeat (50)
    begin
      @(posedge clock);
      #1;
      if (sample_hold)
        sh_cnt++;
      if (int_seq1)
        int_cnt++;
    end
  endtask

  // Expected code of a channel: model level minus low level, scaled, capped
  function automatic logic [11:0] code(input int ch);
    int d;
    d = (500 + 200 * ch - 100) * 4096 / 3000;
    return (d > 4095) ? 12'hfff : d[11:0];
  endfunction

  task automatic test_done;
    $display("compared %0d, wrong %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    test_done;
  end

  initial
  begin
    errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    converter_clock_enable = 1'b0;
    halt = 1'b0;
    fire_a = 1'b0;
    fire_b = 1'b0;
    external_interrupt_two = 1'b0;
    analog_low_reference = 16'h0064;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    wr_reg(adcsq_pkg::ADDR_REFSEL, 16'hc000);
    rd_chk(adcsq_pkg::ADDR_REFSEL, 16'h0000);
    @(posedge clock) converter_clock_enable <= 1'b1;
    repeat (20) @(posedge clock);
    rd_chk(adcsq_pkg::ADDR_REFSEL, 16'h0000);
    wr_reg(adcsq_pkg::ADDR_REFSEL, 16'h4000);
    rd_chk(adcsq_pkg::ADDR_REFSEL, 16'h4000);
    check({14'h0000, reference_select}, 16'h0001);
    rd_chk(16'h711a, 16'h0000);
    @(posedge clock) halt <= 1'b1;
    @(posedge clock);
    #1;
    check({15'h0000, analog_power_up}, 16'h0000);
    @(posedge clock) halt <= 1'b0;
    rd_chk(adcsq_pkg::ADDR_REFSEL, 16'h4000);
    $display("test registers done");
    wr_reg(adcsq_pkg::ADDR_CHSEL0, 16'h0f33);
    wr_reg(adcsq_pkg::ADDR_CHSEL0 + 16'h0002, 16'h000a);
    wr_reg(adcsq_pkg::ADDR_MAXCONV, 16'h0002);
    wr_reg(adcsq_pkg::ADDR_CTRL2, 16'h2b09);
    wait_int(1'b0);
    rd_chk(adcsq_pkg::ADDR_RES_FAST, {4'h0, code(3)});
    rd_chk(adcsq_pkg::ADDR_RES_FAST + 16'h0001, {4'h0, code(3)});
    rd_chk(adcsq_pkg::ADDR_RES_SLOW + 16'h0002, {code(7), 4'h0});
    $display("test software start done");
    @(posedge clock)
    begin
      fire_a <= 1'b1;
      fire_b <= 1'b1;
    end
    @(posedge clock)
    begin
      fire_a <= 1'b0;
      fire_b <= 1'b0;
    end
    wait_int(1'b0);
    wait_int(1'b1);
    rd_chk(adcsq_pkg::ADDR_RES_FAST + 16'h0008, {4'h0, code(10)});
    $display("test pwm start done");
    @(posedge clock) external_interrupt_two <= 1'b1;
    @(posedge clock) external_interrupt_two <= 1'b0;
    wait_int(1'b0);
    $display("test pin start done");
    wr_reg(adcsq_pkg::ADDR_CTRL1, 16'h0330);
    wr_reg(adcsq_pkg::ADDR_CTRL2, 16'h4c00);
    sh_cnt = 0;
    int_cnt = 0;
    step;
    check({15'h0000, sh_cnt == 7 || sh_cnt == 8}, 16'h0001);
    rd_chk(adcsq_pkg::ADDR_SEQ_STATUS, 16'h0081);
    step;
    step;
    check(int_cnt[15:0], 16'h0000);
    rd_chk(adcsq_pkg::ADDR_RES_FAST + 16'h0002, {4'h0, code(15)});
    repeat (3) step;
    check(int_cnt[15:0], 16'h0001);
    $display("test start/stop cascade done");
    test_done;
  end
endmodule // adc_autosequencer_control_bench
